/* emcy_regs.vh */
// Register offsets, field positions, reset values and frame codes of the emergency framer
`ifndef EMCY_REGS_VH
`define EMCY_REGS_VH

`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INT_STAT 8'h08
`define OFS_INT_MASK 8'h0c
`define OFS_FRAME_CNT 8'h10

`define CTRL_EN_BIT 0
`define CTRL_NODE_LSB 8
`define CTRL_NODE_MSB 14
`define CTRL_EN_RST 1'b1
`define NODE_ID_RST 7'h01

`define STAT_BUSY_BIT 8
`define STAT_PEND_LSB 16

`define INT_SENT_BIT 0
`define INT_DROP_BIT 1
`define INT_MASK_RST 2'h0
`define INT_STAT_RST 1'b0

`define EMCY_COB_BASE 11'h080
`define EMCY_DLC 4'h8

`define CODE_CAN 16'h8100
`define CODE_GUARD 16'h8130
`define CODE_RPDO 16'h8210
`define CODE_HW 16'h5000

`define SUB_ADC_TMO 8'h01
`define SUB_ADC_RST 8'h02
`define SUB_ADC_OFS 8'h03
`define SUB_ADC_GAIN 8'h04
`define SUB_ADC_INIT 8'h10
`define SUB_CRC 8'h30
`define SUB_NV_WR 8'h41
`define SUB_NV_RD 8'h42
`define CRC_PROG_MEM 8'h01

`define CAN_EVT_MASK 8'he4

`define ERRREG_GENERIC 0
`define ERRREG_COMM 4
`define ERRREG_MANUF 7

`define NUM_SRC 11
`endif

/* emcy_framer.v */
// Emergency frame builder: fault capture, frame sequencing, APB registers and interrupt
// Operation
// R1 - One emergency frame per detected fault event; here a repeat while still pending, or a fault while disabled, gets no frame
// R2 - Identifier is 080h plus node identifier
// R3 - Bytes 0-1 code, 2 error register, 3-7 field
// R4 - CAN fault: 8100h, event, state, counters
// R5 - Life guarding: reinit controller, send 8130h
// R6 - Short process data: 8210h, minimum DLC
// R7 - Conversion timeout: 5000h, 01h, channel, zero
// R8 - Converter reset failure: 02h, zero, cause
// R9 - Offset calibration 03h, gain calibration 04h
// R10 - Converter init problem: 10h, status value
// R11 - Program memory CRC: 30h, then 1
// R12 - Parameter write error: 41h, block, size
// R13 - Parameter read error: 42h, block, cause
// R14 - Event byte flags 04h/20h/40h/80h only
// R15 - State byte flags passed as eight bits
// R16 - Error register: sticky class bits, bit6 zero
// R17 - Always eight data bytes, unused bytes zero
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "emcy_regs.vh"

module emcy_framer (
	input wire CLK_SYS,
	input wire SRST,
	// APB register port
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	// Fault pulses, each with its data sampled in the same cycle
	input wire CAN_FAULT,
	input wire [7:0] CAN_EVT,
	input wire [7:0] CAN_STATE,
	input wire [7:0] CAN_ERR_CNT,
	input wire [7:0] CAN_BUSOFF_CNT,
	input wire GUARD_FAULT,
	output reg CAN_REINIT,
	input wire RPDO_SHORT,
	input wire [7:0] RPDO_MIN_DLC,
	input wire ADC_TIMEOUT,
	input wire [5:0] ADC_CHAN,
	input wire ADC_RESET_FAIL,
	input wire [3:0] ADC_RESET_CAUSE,
	input wire ADC_OFFSET_FAIL,
	input wire ADC_GAIN_FAIL,
	input wire ADC_INIT_FAIL,
	input wire [7:0] ADC_STATUS,
	input wire PROG_CRC_FAIL,
	input wire NV_WRITE_FAIL,
	input wire [7:0] NV_WR_BLOCK,
	input wire [7:0] NV_WR_SIZE,
	input wire NV_READ_FAIL,
	input wire [7:0] NV_RD_BLOCK,
	input wire [2:0] NV_RD_CAUSE,
	// Frame offered to the CAN transmitter
	output reg TX_VALID,
	input wire TX_READY,
	output reg [10:0] TX_ID,
	output reg [3:0] TX_DLC,
	output reg [63:0] TX_DATA,
	// Level interrupt
	output wire IRQ
);

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_SEND = 2'b10;

	wire [`NUM_SRC-1:0] ev;
	wire [`NUM_SRC-1:0] accept;
	wire [39:0] fld_in [0:`NUM_SRC-1];
	wire [39:0] fld_q [0:`NUM_SRC-1];
	reg [`NUM_SRC-1:0] pend_ff;
	reg [`NUM_SRC-1:0] nxt_pend;
	reg [`NUM_SRC-1:0] clr_mask;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [7:0] errreg_ff;
	reg [7:0] nxt_errreg;
	reg ctrl_en_ff;
	reg [6:0] node_ff;
	wire [1:0] int_stat_q;
	wire [1:0] int_set;
	reg [1:0] int_mask_ff;
	reg [15:0] frame_cnt_ff;
	reg [3:0] sel;
	reg sel_any;
	reg [15:0] sel_code;
	reg [7:0] sel_class;
	reg [39:0] sel_fld;
	reg [31:0] rd_mux;
	reg addr_ok;
	wire wr_acc;
	wire wr_ctrl;
	wire wr_int_stat;
	wire wr_int_mask;
	wire rd_setup;
	wire load;
	wire sent;
	wire drop;
	wire [10:0] frame_id;
	wire [63:0] frame_word;
	integer i;

	assign ev = {NV_READ_FAIL, NV_WRITE_FAIL, PROG_CRC_FAIL, ADC_INIT_FAIL, ADC_GAIN_FAIL,
		ADC_OFFSET_FAIL, ADC_RESET_FAIL, ADC_TIMEOUT, RPDO_SHORT, GUARD_FAULT, CAN_FAULT};
	// A fault counts only while framing is enabled
	assign accept = ev & {`NUM_SRC{ctrl_en_ff}};

	// Fault-specific bytes 3..7, byte 3 in the low bits; undefined bytes are zero
	assign fld_in[0] = {8'h00, CAN_BUSOFF_CNT, CAN_ERR_CNT, CAN_STATE,
		CAN_EVT & `CAN_EVT_MASK}; // [R4] [R14] [R15]
	assign fld_in[1] = 40'h00_0000_0000; // [R5] [R17]
	assign fld_in[2] = {32'h0000_0000, RPDO_MIN_DLC}; // [R6]
	assign fld_in[3] = {24'h00_0000, 2'b00, ADC_CHAN, `SUB_ADC_TMO}; // [R7]
	assign fld_in[4] = {16'h0000, 4'h0, ADC_RESET_CAUSE, 8'h00, `SUB_ADC_RST}; // [R8]
	assign fld_in[5] = {32'h0000_0000, `SUB_ADC_OFS}; // [R9]
	assign fld_in[6] = {32'h0000_0000, `SUB_ADC_GAIN}; // [R9]
	assign fld_in[7] = {24'h00_0000, ADC_STATUS, `SUB_ADC_INIT}; // [R10]
	assign fld_in[8] = {24'h00_0000, `CRC_PROG_MEM, `SUB_CRC}; // [R11]
	assign fld_in[9] = {16'h0000, NV_WR_SIZE, NV_WR_BLOCK, `SUB_NV_WR}; // [R12]
	assign fld_in[10] = {16'h0000, 5'h00, NV_RD_CAUSE, NV_RD_BLOCK, `SUB_NV_RD}; // [R13]

	// Each source keeps its own snapshot so a later fault elsewhere cannot corrupt it.
	// A repeat of the same fault while still pending overwrites the snapshot.
	genvar g;
	generate
		for (g = 0; g < `NUM_SRC; g = g + 1) begin : snap
			emcy_snap #(
				.W(40)
			) u_snap (
				.clk(CLK_SYS),
				.srst(SRST),
				.capture(accept[g]),
				.d(fld_in[g]),
				.snap_ff(fld_q[g])
			);
		end
	endgenerate

	// Lowest index wins: communication faults go out before converter faults
	always @* begin
		sel = 4'h0;
		sel_any = 1'b0;
		for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
			if (pend_ff[i]) begin
				sel = i[3:0];
				sel_any = 1'b1;
			end
		end
	end

	always @* begin
		sel_fld = fld_q[sel];
		sel_class = 8'h00;
		sel_class[`ERRREG_GENERIC] = 1'b1; // [R16]
		case (sel)
			4'd0: begin
				sel_code = `CODE_CAN; // [R4]
				sel_class[`ERRREG_COMM] = 1'b1;
			end
			4'd1: begin
				sel_code = `CODE_GUARD; // [R5]
				sel_class[`ERRREG_COMM] = 1'b1;
			end
			4'd2: begin
				sel_code = `CODE_RPDO; // [R6]
				sel_class[`ERRREG_COMM] = 1'b1;
			end
			default: begin
				sel_code = `CODE_HW; // [R7] [R8] [R9] [R10] [R11] [R12] [R13]
				sel_class[`ERRREG_MANUF] = 1'b1; // [R16]
			end
		endcase
	end

	assign load = (state_ff == ST_IDLE) && sel_any;
	assign sent = (state_ff == ST_SEND) && TX_READY;

	// Source handed to the frame buffer this cycle; its pending bit is free again
	always @* begin
		clr_mask = {`NUM_SRC{1'b0}};
		if (load) begin
			clr_mask[sel] = 1'b1;
		end
	end

	// Faults while disabled, or a repeat before the first one was loaded into the frame buffer, lose a frame.
	// A repeat in the very cycle its predecessor is loaded is not a loss.
	assign drop = |(ev & ((pend_ff & ~clr_mask) | {`NUM_SRC{~ctrl_en_ff}}));

	// Set after clear: a fault in the loading cycle still earns its own frame
	always @* begin
		nxt_pend = (pend_ff & ~clr_mask) | accept; // [R1]
	end

	// One frame buffer: the next frame waits until the transmitter has taken this one
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (sel_any) begin
					nxt_state = ST_SEND;
				end
			end
			ST_SEND: begin
				if (TX_READY) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Class bits accumulate until reset; bit 6 is never set
	always @* begin
		nxt_errreg = errreg_ff;
		if (load) begin
			nxt_errreg = errreg_ff | sel_class; // [R16]
		end
	end

	// Identifier and payload as they go on the bus; byte 0 is the low code byte
	assign frame_id = `EMCY_COB_BASE + {4'h0, node_ff}; // [R2]
	assign frame_word = {sel_fld, nxt_errreg, sel_code[15:8], sel_code[7:0]}; // [R3]

	always @(posedge CLK_SYS) begin
		if (SRST) begin
			state_ff <= ST_IDLE;
			pend_ff <= {`NUM_SRC{1'b0}};
			errreg_ff <= 8'h00;
			TX_VALID <= 1'b0;
			TX_ID <= 11'h000;
			TX_DLC <= 4'h0;
			TX_DATA <= 64'h0000_0000_0000_0000;
			CAN_REINIT <= 1'b0;
			frame_cnt_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			pend_ff <= nxt_pend;
			errreg_ff <= nxt_errreg;
			// One pulse per accepted guard fault; the controller restart itself lies outside
			CAN_REINIT <= accept[1]; // [R5]
			if (load) begin
				TX_VALID <= 1'b1;
				TX_ID <= frame_id; // [R2]
				TX_DLC <= `EMCY_DLC; // [R17]
				TX_DATA <= frame_word; // [R3]
			end else if (sent) begin
				TX_VALID <= 1'b0;
				frame_cnt_ff <= frame_cnt_ff + 16'h0001;
			end
		end
	end

	// APB slave: no wait states, read data registered in the setup cycle
	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign wr_ctrl = wr_acc && (PADDR == `OFS_CTRL);
	assign wr_int_stat = wr_acc && (PADDR == `OFS_INT_STAT);
	assign wr_int_mask = wr_acc && (PADDR == `OFS_INT_MASK);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;

	always @* begin
		addr_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		case (PADDR)
			`OFS_CTRL: begin
				rd_mux[`CTRL_EN_BIT] = ctrl_en_ff;
				rd_mux[`CTRL_NODE_MSB:`CTRL_NODE_LSB] = node_ff;
			end
			`OFS_STATUS: begin
				rd_mux[7:0] = errreg_ff;
				rd_mux[`STAT_BUSY_BIT] = TX_VALID;
				rd_mux[`STAT_PEND_LSB+`NUM_SRC-1:`STAT_PEND_LSB] = pend_ff;
			end
			`OFS_INT_STAT: begin
				rd_mux[1:0] = int_stat_q;
			end
			`OFS_INT_MASK: begin
				rd_mux[1:0] = int_mask_ff;
			end
			`OFS_FRAME_CNT: begin
				rd_mux[15:0] = frame_cnt_ff;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	assign int_set[`INT_SENT_BIT] = sent;
	assign int_set[`INT_DROP_BIT] = drop;

	// Hardware set wins over a same-cycle write-one-to-clear inside each cell
	generate
		for (g = 0; g < 2; g = g + 1) begin : istat
			emcy_w1c_bit #(
				.RST(`INT_STAT_RST)
			) u_bit (
				.clk(CLK_SYS),
				.srst(SRST),
				.set(int_set[g]),
				.clr(wr_int_stat && PWDATA[g]),
				.bit_ff(int_stat_q[g])
			);
		end
	endgenerate

	always @(posedge CLK_SYS) begin
		if (SRST) begin
			ctrl_en_ff <= `CTRL_EN_RST;
			node_ff <= `NODE_ID_RST;
			int_mask_ff <= `INT_MASK_RST;
			PRDATA <= 32'h0000_0000;
		end else begin
			if (rd_setup) begin
				PRDATA <= rd_mux;
			end
			if (wr_ctrl) begin
				ctrl_en_ff <= PWDATA[`CTRL_EN_BIT];
				node_ff <= PWDATA[`CTRL_NODE_MSB:`CTRL_NODE_LSB];
			end
			if (wr_int_mask) begin
				int_mask_ff <= PWDATA[1:0];
			end
		end
	end

	assign IRQ = |(int_stat_q & int_mask_ff);

endmodule

// One fault source's field snapshot, loaded on the capture strobe
module emcy_snap #(
	parameter W = 40
) (
	input wire clk,
	input wire srst,
	input wire capture,
	input wire [W-1:0] d,
	output reg [W-1:0] snap_ff
);
	always @(posedge clk) begin
		if (srst) begin
			snap_ff <= {W{1'b0}};
		end else if (capture) begin
			snap_ff <= d;
		end
	end
endmodule

// Sticky event bit, cleared by writing one; a same-cycle set wins
module emcy_w1c_bit #(
	parameter [0:0] RST = 1'b0
) (
	input wire clk,
	input wire srst,
	input wire set,
	input wire clr,
	output reg bit_ff
);
	always @(posedge clk) begin
		if (srst) begin
			bit_ff <= RST;
		end else if (set) begin
			bit_ff <= 1'b1;
		end else if (clr) begin
			bit_ff <= 1'b0;
		end
	end
endmodule

/* emcy_framer_chk.sv */
// Checker of the frame port of the emergency framer
`timescale 1ns/1ps
module emcy_framer_chk (
	input wire CLK_SYS,
	input wire SRST,
	input wire GUARD_FAULT,
	input wire CAN_REINIT,
	input wire TX_VALID,
	input wire TX_READY,
	input wire [10:0] TX_ID,
	input wire [3:0] TX_DLC,
	input wire [63:0] TX_DATA
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);
	a_dlc_eight: assert property (TX_VALID |-> TX_DLC == 4'h8)
		else $error("frame length not eight");
	a_byte7_zero: assert property (TX_VALID |-> TX_DATA[63:56] == 8'h0)
		else $error("last byte not zero");
	a_errreg_bits: assert property (TX_VALID |-> TX_DATA[16] && !TX_DATA[22])
		else $error("error register bits wrong");
	a_id_base: assert property (TX_VALID |-> TX_ID[10:7] == 4'h1)
		else $error("identifier base wrong");
	a_frame_hold: assert property (TX_VALID && !TX_READY |=>
		TX_VALID && $stable(TX_DATA) && $stable(TX_ID)) else $error("frame not held");
	a_valid_drop: assert property (TX_VALID && TX_READY |=> !TX_VALID)
		else $error("frame offered twice");
	a_reinit_cause: assert property (CAN_REINIT |-> $past(GUARD_FAULT))
		else $error("reinit without guard fault");
	a_reinit_pulse: assert property (CAN_REINIT |=> !CAN_REINIT)
		else $error("reinit longer than a cycle");
	a_code_known: assert property (TX_VALID |-> TX_DATA[15:0] inside
		{16'h8100, 16'h8130, 16'h8210, 16'h5000}) else $error("unknown code");
	a_event_flags: assert property (TX_VALID && TX_DATA[15:0] == 16'h8100
		|-> (TX_DATA[31:24] & 8'h1b) == 8'h0) else $error("bad event flags");
	c_sent: cover property (TX_VALID && TX_READY);
	c_stall: cover property (TX_VALID && !TX_READY ##1 TX_VALID);
	c_reinit: cover property (CAN_REINIT);
endmodule
bind emcy_framer emcy_framer_chk u_chk (.CLK_SYS(CLK_SYS), .SRST(SRST),
	.GUARD_FAULT(GUARD_FAULT), .CAN_REINIT(CAN_REINIT), .TX_VALID(TX_VALID),
	.TX_READY(TX_READY), .TX_ID(TX_ID), .TX_DLC(TX_DLC), .TX_DATA(TX_DATA));

/* can_tx_model.sv */
// Transmitter model: takes an offered frame after a chosen wait
`timescale 1ns/1ps
module can_tx_model (
	input wire clk,
	input wire rst,
	input wire valid,
	input wire [1:0] wait_cyc,
	output wire ready
);
	reg [1:0] cnt_ff;
	reg rdy_ff;
	assign ready = rdy_ff;
	// Ready is a single pulse so every frame is taken exactly once
	always @(posedge clk) begin
		if (rst || !valid || rdy_ff) begin
			cnt_ff <= 2'h0;
			rdy_ff <= 1'b0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
			rdy_ff <= (cnt_ff >= wait_cyc);
		end
	end
endmodule

/* tb_emcy_framer.sv */
// Self-checking bench of the emergency framer
`timescale 1ns/1ps
module tb_emcy_framer;
	reg clk, rst, psel, pen, pwr, e;
	reg [7:0] pa, er;
	reg [31:0] pwd, r;
	reg [10:0] flt;
	reg [63:0] fd;
	reg [1:0] dly;
	reg [6:0] nd;
	wire [31:0] prd;
	wire prdy, perr, rdy, tv, irq, reinit;
	wire [10:0] tid;
	wire [3:0] tdlc;
	wire [63:0] tdat;
	reg [78:0] q[$];
	integer errors = 0, num_checks = 0, cyc = 0, nf = 0, n;
	emcy_framer u_dut (.CLK_SYS(clk), .SRST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.CAN_FAULT(flt[0]), .CAN_EVT(fd[7:0]), .CAN_STATE(fd[15:8]), .CAN_ERR_CNT(fd[23:16]),
		.CAN_BUSOFF_CNT(fd[31:24]), .GUARD_FAULT(flt[1]), .CAN_REINIT(reinit),
		.RPDO_SHORT(flt[2]), .RPDO_MIN_DLC(fd[7:0]), .ADC_TIMEOUT(flt[3]), .ADC_CHAN(fd[5:0]),
		.ADC_RESET_FAIL(flt[4]), .ADC_RESET_CAUSE(4'h1 << fd[33:32]), .ADC_OFFSET_FAIL(flt[5]),
		.ADC_GAIN_FAIL(flt[6]), .ADC_INIT_FAIL(flt[7]), .ADC_STATUS(fd[7:0]),
		.PROG_CRC_FAIL(flt[8]), .NV_WRITE_FAIL(flt[9]), .NV_WR_BLOCK(fd[7:0]),
		.NV_WR_SIZE(fd[15:8]), .NV_READ_FAIL(flt[10]), .NV_RD_BLOCK(fd[7:0]),
		.NV_RD_CAUSE(fd[34] ? 3'h4 : 3'h1 << fd[33]), .TX_VALID(tv), .TX_READY(rdy),
		.TX_ID(tid), .TX_DLC(tdlc), .TX_DATA(tdat), .IRQ(irq));
	can_tx_model u_tx (.clk(clk), .rst(rst), .valid(tv), .wait_cyc(dly), .ready(rdy));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", num_checks, errors);
			if (errors == 0 && num_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task chk(input [78:0] g, input [78:0] x);
		begin
			num_checks = num_checks + 1;
			if (g !== x) begin
				errors = errors + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwr <= w;
			pa <= a;
			pwd <= d;
			@(posedge clk);
			pen <= 1'b1;
			@(posedge clk);
			while (prdy !== 1'b1) @(posedge clk);
			r = prd;
			e = perr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask
	function [39:0] fld(input integer s, input [63:0] v);
		begin
			case (s)
			0: fld = {8'h0, v[31:24], v[23:16], v[15:8], v[7:0] & 8'he4};
			2: fld = {32'h0, v[7:0]};
			3: fld = {24'h0, 2'h0, v[5:0], 8'h01};
			4: fld = {16'h0, 4'h0, 4'h1 << v[33:32], 16'h0002};
			5: fld = 40'h03;
			6: fld = 40'h04;
			7: fld = {24'h0, v[7:0], 8'h10};
			8: fld = 40'h0130;
			9: fld = {16'h0, v[15:8], v[7:0], 8'h41};
			10: fld = {16'h0, 5'h0, v[34] ? 3'h4 : 3'h1 << v[33], v[7:0], 8'h42};
			default: fld = 40'h0;
			endcase
		end
	endfunction
	// Expected frames are queued in priority order, lowest source first
	task fire(input en, input [10:0] m);
		integer i;
		reg [63:0] v;
		reg [15:0] c;
		begin
			v = {$urandom, $urandom};
			@(posedge clk);
			fd <= v;
			flt <= m;
			dly <= $urandom % 4;
			for (i = 0; i < 11; i = i + 1) if (m[i] && en) begin
				c = i == 0 ? 16'h8100 : i == 1 ? 16'h8130 : i == 2 ? 16'h8210 : 16'h5000;
				er = er | 8'h01 | (i < 3 ? 8'h10 : 8'h80);
				q.push_back({11'h080 + nd, 4'h8, fld(i, v), er, c});
			end
			@(posedge clk);
			flt <= 11'h0;
			repeat (6) @(posedge clk);
			while (q.size() != 0) @(posedge clk);
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc > 20000) begin
			errors = errors + 1;
			tally_and_finish;
		end
		if (tv === 1'b1 && rdy === 1'b1) begin
			chk({tid, tdlc, tdat}, q.size() ? q.pop_front() : 79'h0);
			nf = nf + 1;
		end
	end
	initial begin
		{rst, psel, pen, pwr, pa, pwd, flt, fd, dly} = {1'b1, 120'h0};
		er = 8'h0;
		nd = 7'h01;
		r = $urandom(32'h1afa);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 8'h00, 32'h0);
		chk({e, r}, 32'h101);
		apb(1'b0, 8'h44, 32'h0);
		chk({e, r}, {1'b1, 32'h0});
		$display("test reset done");
		nd = $urandom;
		apb(1'b1, 8'h00, {17'h0, nd, 8'h01});
		apb(1'b1, 8'h0c, 32'h3);
		for (n = 0; n < 33; n = n + 1)
			fire(1'b1, 11'h1 << (n % 11));
		@(negedge clk);
		chk(irq, 1'b1);
		apb(1'b1, 8'h0c, 32'h0);
		@(negedge clk);
		chk(irq, 1'b0);
		apb(1'b1, 8'h08, 32'h3);
		apb(1'b1, 8'h0c, 32'h3);
		@(negedge clk);
		chk(irq, 1'b0);
		$display("test single faults done");
		fire(1'b1, 11'h7ff);
		apb(1'b1, 8'h08, 32'h3);
		apb(1'b1, 8'h00, {17'h0, nd, 8'h00});
		fire(1'b0, 11'h001);
		apb(1'b0, 8'h08, 32'h0);
		chk(r, 32'h2);
		apb(1'b0, 8'h04, 32'h0);
		chk(r, {24'h0, er});
		apb(1'b0, 8'h10, 32'h0);
		chk(r, nf);
		$display("test priority and drop done");
		tally_and_finish;
	end
endmodule
